// ---- hw/scan_halt_ctrl.sv ----
// Scanner sequencing against debug halts, with Avalon-MM registers
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scan_halt_ctrl #(
    parameter int WDT_CYCLES = scan_halt_pkg::WDT_PERIOD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [scan_halt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Debug unit
    input wire logic halt_req,
    input wire scan_halt_pkg::halt_src_e halt_src,
    input wire logic single_step,
    input wire logic sw_breakpoint,
    input wire logic debug_exit,
    output logic debug_entered,
    output logic exec_from_debug_reg,
    // CPU pipeline
    input wire logic instr_fetch,
    input wire logic instr_sets_go,
    input wire logic scan_trigger,
    output logic instr_stall,
    output logic instr_execute,
    // Program flash read port
    output logic flash_read,
    output logic [15:0] flash_addr,
    // Interrupt and watchdog reset
    output logic irq,
    output logic wdt_reset
);
    import scan_halt_pkg::*;
    typedef enum logic [2:0] {
        S_RUN,
        S_ACCESS,
        S_HALT_PEND,
        S_HALTED
    } state_e;
    typedef struct packed {
        state_e state;
        logic [7:0] ctrl;
        logic [15:0] addr;
        logic [15:0] end_addr;
        logic [7:0] irq4;
        logic [7:0] mask;
        logic wdt_en;
        logic [1:0] acc_cnt;
        logic deferred_scan;
        logic deferred_go;
        logic deferred_instr;
        logic from_debug_reg;
        logic [31:0] rdata;
        logic wait_n;
        logic debug_entered;
        logic exec;
        logic stall;
        logic fread;
        logic irq;
    } regs_s;
    regs_s r, next_r;
    logic wdt_expire;
    logic [1:0] mode;
    logic burst;
    logic conc;
    logic scan_want;
    logic event_done;
    logic bus_req;
    logic [7:0] wbyte;

    scan_watchdog #(.PERIOD(WDT_CYCLES)) u_wdt (
        .clk(clk),
        .rst(rst),
        .enable(r.wdt_en),
        .clear(1'b0),
        .expire(wdt_expire)
    );

    always_comb begin
        next_r = r;
        mode = r.ctrl[CTRL_MODE_LO +: CTRL_MODE_W];
        burst = (mode == MODE_BURST);
        conc = (mode == MODE_CONCURRENT) || (mode == MODE_TRIGGERED);
        scan_want = r.ctrl[CTRL_EN] && (mode == MODE_PEEK ? instr_fetch
            : (mode == MODE_TRIGGERED ? scan_trigger : instr_fetch));
        event_done = 1'b0;
        bus_req = avs_read || avs_write;
        wbyte = avs_writedata[7:0];
        next_r.exec = 1'b0;
        next_r.fread = 1'b0;
        next_r.debug_entered = (r.state == S_HALTED);
        next_r.stall = 1'b0;
        // Register bus: one wait cycle, then answer
        next_r.wait_n = bus_req && !r.wait_n;
        if (bus_req && !r.wait_n) begin
            // Reads stay available while halted
            case (avs_address)
                OFF_CTRL: next_r.rdata = {24'h0, r.ctrl};
                OFF_LADR: next_r.rdata = {24'h0, r.addr[7:0]};
                OFF_HADR: next_r.rdata = {24'h0, r.addr[15:8]};
                OFF_IRQ4: next_r.rdata = {24'h0, r.irq4};
                OFF_MASK: next_r.rdata = {24'h0, r.mask};
                OFF_WDT: next_r.rdata = {31'h0, r.wdt_en};
                OFF_STAT: next_r.rdata = {28'h0, r.deferred_scan,
                    r.deferred_go, r.from_debug_reg, r.state == S_HALTED};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        case (r.state)
            S_RUN: begin
                if (r.ctrl[CTRL_EN] && r.ctrl[CTRL_GO] && burst
                    && halt_req) begin
                    // Burst suspended between accesses
                    next_r.state = S_HALTED;
                end else if (r.ctrl[CTRL_EN] && r.ctrl[CTRL_GO] && burst)
                begin
                    next_r.state = S_ACCESS;
                    next_r.acc_cnt = 2'(FLASH_CYCLES - 1);
                    next_r.fread = 1'b1;
                end else if (halt_req) begin
                    case (halt_src)
                        HALT_EXTERNAL: begin
                            // Pending fetch deferred past halt
                            next_r.deferred_scan = scan_want && !burst;
                            next_r.deferred_instr = instr_fetch;
                            // Go instruction halted, burst waits
                            next_r.deferred_go = instr_sets_go;
                            next_r.state = S_HALTED;
                        end
                        HALT_ADDR_BP: begin
                            if (instr_sets_go) begin
                                // Entry before go executes
                                next_r.deferred_go = 1'b1;
                                next_r.deferred_instr = 1'b1;
                                next_r.state = S_HALTED;
                            end else if (conc && scan_want) begin
                                // Scan first, instruction after exit
                                next_r.deferred_instr = 1'b1;
                                next_r.state = S_HALT_PEND;
                                next_r.acc_cnt = 2'(FLASH_CYCLES - 1);
                                next_r.fread = 1'b1;
                            end else begin
                                next_r.deferred_instr = instr_fetch;
                                next_r.state = S_HALTED;
                            end
                        end
                        HALT_DATA_BP: begin
                            // Instruction runs, scan postponed
                            next_r.exec = instr_fetch;
                            next_r.deferred_scan = scan_want;
                            next_r.state = S_HALTED;
                        end
                        default: next_r.state = S_HALTED;
                    endcase
                end else if (sw_breakpoint) begin
                    if (instr_sets_go) begin
                        // Go executes from debug register at exit
                        next_r.from_debug_reg = 1'b1;
                        next_r.deferred_go = 1'b1;
                        next_r.state = S_HALTED;
                    end else if (conc && scan_want) begin
                        // Stalled breakpoint: scan first
                        next_r.state = S_HALT_PEND;
                        next_r.acc_cnt = 2'(FLASH_CYCLES - 1);
                        next_r.fread = 1'b1;
                        next_r.stall = 1'b1;
                    end else begin
                        next_r.state = S_HALTED;
                    end
                end else if (single_step && instr_sets_go) begin
                    next_r.deferred_go = 1'b1;
                    next_r.deferred_instr = 1'b1;
                    next_r.state = S_HALTED;
                end else if (single_step) begin
                    next_r.exec = instr_fetch;
                    if (scan_want) begin
                        // Stepped scan reads before re-entry
                        next_r.state = S_HALT_PEND;
                        next_r.acc_cnt = 2'(FLASH_CYCLES - 1);
                        next_r.fread = 1'b1;
                    end else begin
                        next_r.state = S_HALTED;
                    end
                end else begin
                    next_r.exec = instr_fetch;
                    if (scan_want && !burst && !r.stall) begin
                        next_r.fread = 1'b1;
                        event_done = 1'b1;
                        // Scan takes the instruction's slot; peek does not
                        if (conc) begin
                            next_r.stall = 1'b1;
                            next_r.exec = 1'b0;
                        end
                    end
                    if (instr_sets_go && next_r.exec) begin
                        next_r.ctrl[CTRL_GO] = 1'b1;
                    end
                end
            end
            S_ACCESS: begin
                // Current flash access always finishes
                next_r.fread = (r.acc_cnt != 2'h0);
                if (r.acc_cnt != 2'h0) begin
                    next_r.acc_cnt = r.acc_cnt - 2'h1;
                end else begin
                    event_done = 1'b1;
                    next_r.state = halt_req ? S_HALTED : S_RUN;
                end
            end
            S_HALT_PEND: begin
                next_r.fread = (r.acc_cnt != 2'h0);
                if (r.acc_cnt != 2'h0) begin
                    next_r.acc_cnt = r.acc_cnt - 2'h1;
                end else begin
                    event_done = 1'b1;
                    next_r.state = S_HALTED;
                end
            end
            S_HALTED: begin
                // Address and mode held while frozen
                if (debug_exit) begin
                    next_r.state = S_RUN;
                    next_r.debug_entered = 1'b0;
                    next_r.exec = r.deferred_instr || r.from_debug_reg;
                    next_r.fread = r.deferred_scan;
                    event_done = r.deferred_scan;
                    if (r.deferred_go) begin
                        next_r.ctrl[CTRL_GO] = 1'b1;
                    end
                    next_r.deferred_scan = 1'b0;
                    next_r.deferred_go = 1'b0;
                    next_r.deferred_instr = 1'b0;
                    next_r.from_debug_reg = 1'b0;
                end
            end
            default: next_r.state = S_RUN;
        endcase
        // Advance address once per completed read
        if (event_done) begin
            next_r.addr = r.addr + 16'h0001;
            if (r.addr == r.end_addr) begin
                next_r.ctrl[CTRL_GO] = 1'b0;
                next_r.irq4[IRQ_SCAN_BIT] = 1'b1;
            end
        end
        // Writes land at the edge that ends the answer cycle
        if (avs_write && r.wait_n) begin
            case (avs_address)
                OFF_CTRL: next_r.ctrl = wbyte | (next_r.ctrl
                    & (8'h01 << CTRL_GO));
                OFF_LADR: next_r.addr[7:0] = wbyte;
                OFF_HADR: next_r.end_addr[7:0] = wbyte;
                // Write one clears, a same-cycle set wins
                OFF_IRQ4: next_r.irq4 = next_r.irq4 & ~(wbyte & ~(r.irq4
                    ^ next_r.irq4) | (wbyte & r.irq4 & ~next_r.irq4));
                OFF_MASK: next_r.mask = wbyte;
                OFF_WDT: next_r.wdt_en = avs_writedata[0];
                default: next_r.mask = next_r.mask;
            endcase
        end
        next_r.irq = |(next_r.irq4 & next_r.mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.state <= S_RUN;
            r.ctrl <= CTRL_RESET;
            r.mask <= MASK_RESET;
            r.addr <= ADDR_RESET;
            r.end_addr <= END_RESET;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_reset <= 1'b0;
        end else begin
            wdt_reset <= wdt_expire;
        end
    end

    assign avs_readdata = r.rdata;
    assign avs_waitrequest = !r.wait_n;
    assign debug_entered = r.debug_entered;
    assign exec_from_debug_reg = r.from_debug_reg;
    assign instr_stall = r.stall;
    assign instr_execute = r.exec;
    assign flash_read = r.fread;
    assign flash_addr = r.addr;
    assign irq = r.irq;
endmodule
`default_nettype wire

// ---- hw/scan_halt_pkg.sv ----
// Constants and types shared by the scanner halt-interaction block
//
// Contract
// - Watchdog keeps running regardless of scanner activity
// - Scanner freezes while halted until user resume
// - Control and low address stay readable while halted
// - Missed peek happens after exit when instruction runs; after an address breakpoint the code runs the instruction without the peek
// - Halt before scan cycle defers scan and instruction
// - Halt on go-setting instruction defers burst start
// - Other burst halts finish current flash access first
// - Halt suspends burst; resume at exit
// - Address breakpoint: scan completes before entry
// - Data breakpoint: executes, entry, requested scan postponed
// - Single step: ready scan reads before re-entry
// - Stalled software breakpoint: scan first, then entry
// - Breakpoint on go instruction: entry first, burst completes
// - Software breakpoint on go: execute from debug register
package scan_halt_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_LADR = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_HADR = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ4 = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_WDT = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_STAT = 4'h6;
    // Control register fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_GO = 6;
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_W = 2;
    localparam logic [1:0] MODE_CONCURRENT = 2'h0;
    localparam logic [1:0] MODE_TRIGGERED = 2'h1;
    localparam logic [1:0] MODE_PEEK = 2'h2;
    localparam logic [1:0] MODE_BURST = 2'h3;
    localparam int IRQ_SCAN_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] END_RESET = 16'h00FF;
    // Watchdog period in system clock cycles
    localparam int WDT_PERIOD = 4096;
    localparam int FLASH_CYCLES = 2;
    typedef enum logic [1:0] {
        HALT_NONE,
        HALT_EXTERNAL,
        HALT_ADDR_BP,
        HALT_DATA_BP
    } halt_src_e;
endpackage

// ---- hw/scan_watchdog.sv ----
// Free-running watchdog that scanner activity cannot pause
`timescale 1ns/1ps
`default_nettype none
module scan_watchdog #(
    parameter int PERIOD = scan_halt_pkg::WDT_PERIOD
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic clear,
    // Expiry pulse
    output logic expire
);
    import scan_halt_pkg::*;
    typedef struct packed {
        logic [31:0] count;
        logic expire;
    } wdt_s;
    wdt_s r, next_r;
    always_comb begin
        next_r = r;
        next_r.expire = 1'b0;
        // Counts on every cycle, scan or not
        if (clear || !enable) begin
            next_r.count = 32'h0000_0000;
        end else if (r.count == 32'(PERIOD - 1)) begin
            next_r.count = 32'h0000_0000;
            next_r.expire = 1'b1;
        end else begin
            next_r.count = r.count + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign expire = r.expire;
endmodule
`default_nettype wire

// ---- tb/debug_partner.sv ----
// Debug controller and CPU pipeline model
`timescale 1ns/1ps
`default_nettype none
module debug_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic halt_cmd,
    input wire scan_halt_pkg::halt_src_e src_cmd,
    input wire logic exit_cmd,
    // Block status
    input wire logic debug_entered,
    // To the block
    output logic halt_req,
    output var scan_halt_pkg::halt_src_e halt_src,
    output logic debug_exit,
    output logic instr_fetch,
    output logic scan_trigger
);
    import scan_halt_pkg::*;
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_req <= 1'b0;
            halt_src <= HALT_NONE;
            debug_exit <= 1'b0;
            instr_fetch <= 1'b0;
            scan_trigger <= 1'b0;
        end else begin
            // Halt held until the block reports entry
            halt_req <= halt_cmd && !debug_entered;
            halt_src <= halt_cmd ? src_cmd : HALT_NONE;
            // Exit only from a halt, one pulse
            debug_exit <= exit_cmd && debug_entered && !debug_exit;
            instr_fetch <= !debug_entered;
            scan_trigger <= !scan_trigger;
        end
    end
endmodule
`default_nettype wire

// ---- tb/scan_halt_assertions.sv ----
// Port assertions for the scanner halt-interaction block
`timescale 1ns/1ps
`default_nettype none
module scan_halt_assertions #(
    parameter int WDT_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic [scan_halt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Debug and pipeline
    input wire logic debug_exit,
    input wire logic debug_entered,
    input wire logic instr_stall,
    input wire logic instr_execute,
    input wire logic flash_read,
    input wire logic [15:0] flash_addr,
    // Interrupt and watchdog
    input wire logic irq,
    input wire logic wdt_reset
);
    import scan_halt_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer not one cycle after request");
    property p_upper_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits not zero");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address > OFF_STAT
            |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_frozen;
        (debug_entered && !debug_exit) [*4]
            |-> !flash_read && $stable(flash_addr);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("scanner moved while halted");
    property p_no_exec;
        (debug_entered && !debug_exit) [*2] |-> !instr_execute;
    endproperty
    a_no_exec: assert property (p_no_exec)
        else $error("instruction executed while halted");
    property p_stall_excl;
        instr_stall |-> !instr_execute;
    endproperty
    a_stall_excl: assert property (p_stall_excl)
        else $error("stall and execute together");
    property p_wdt_pulse;
        wdt_reset |=> !wdt_reset [*8];
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse)
        else $error("watchdog expiry too close");
    property p_mask_off;
        avs_write && !avs_waitrequest && avs_address == OFF_MASK
            && avs_writedata[7:0] == 8'h00 |-> ##3 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt high with mask clear");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the scanner halt-interaction block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scan_halt_pkg::*;
    typedef struct {
        logic [3:0] a;
        logic w;
        logic [31:0] d;
    } row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic halt_cmd = 1'b0;
    logic exit_cmd = 1'b0;
    logic single_step = 1'b0;
    logic sw_breakpoint = 1'b0;
    logic instr_sets_go = 1'b0;
    halt_src_e src_cmd = HALT_NONE;
    halt_src_e halt_src;
    logic [31:0] avs_readdata, q;
    logic [15:0] flash_addr, save;
    logic avs_waitrequest, halt_req, debug_exit, debug_entered;
    logic exec_from_debug_reg, instr_fetch, scan_trigger, instr_stall;
    logic instr_execute, flash_read, irq, wdt_reset;
    int err_count = 0;
    int cmp_count = 0;
    int s, m;
    row_s rows[9] = '{
        '{OFF_CTRL, 1'b0, 32'h0000_0000},
        '{OFF_LADR, 1'b0, 32'h0000_0000},
        '{OFF_IRQ4, 1'b0, 32'h0000_0000},
        '{OFF_MASK, 1'b0, 32'h0000_0000},
        '{OFF_MASK, 1'b1, 32'h0000_0000},
        '{OFF_MASK, 1'b1, 32'h0000_0080},
        '{OFF_MASK, 1'b0, 32'h0000_0080},
        '{4'h7, 1'b1, 32'h0000_00FF},
        '{4'hF, 1'b0, 32'h0000_0000}};

    always #25 clk = ~clk;

    scan_halt_ctrl #(.WDT_CYCLES(16)) dut (.clk, .rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .halt_req, .halt_src, .single_step,
        .sw_breakpoint, .debug_exit, .debug_entered, .exec_from_debug_reg,
        .instr_fetch, .instr_sets_go, .scan_trigger, .instr_stall,
        .instr_execute, .flash_read, .flash_addr, .irq, .wdt_reset);
    debug_partner partner (.clk, .rst, .halt_cmd, .src_cmd, .exit_cmd,
        .debug_entered, .halt_req, .halt_src, .debug_exit, .instr_fetch,
        .scan_trigger);

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w,
            input logic [31:0] d);
        int n = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = avs_readdata;
        if (n == 20) err_count++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_for(ref logic s, input logic v);
        int n = 0;
        @(posedge clk);
        while (s !== v && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n == 300) err_count++;
    endtask
    task automatic pulse_exit();
        exit_cmd <= 1'b1;
        @(posedge clk);
        exit_cmd <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(avs_waitrequest, 32'h0000_0001);
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk(q, rows[i].d);
        end
        // Burst suspended by an external halt, then resumed
        bus(OFF_HADR, 1'b1, 32'h0000_000F);
        bus(OFF_CTRL, 1'b1, 32'h0000_00C3);
        wait_for(flash_read, 1'b1);
        halt_cmd <= 1'b1;
        src_cmd <= HALT_EXTERNAL;
        wait_for(debug_entered, 1'b1);
        halt_cmd <= 1'b0;
        repeat (4) @(posedge clk);
        save = flash_addr;
        repeat (6) @(posedge clk);
        chk(flash_addr, save);
        bus(OFF_LADR, 1'b0, 32'h0000_0000);
        chk(q, 32'(save[7:0]));
        bus(OFF_CTRL, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_00C3);
        pulse_exit();
        wait_for(flash_read, 1'b1);
        chk(32'(flash_addr - save <= 16'h0001), 32'h0000_0001);
        wait_for(irq, 1'b1);
        chk(irq, 32'h0000_0001);
        bus(OFF_IRQ4, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0080);
        bus(OFF_MASK, 1'b1, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0000_0000);
        bus(OFF_MASK, 1'b1, 32'h0000_0080);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0000_0001);
        bus(OFF_IRQ4, 1'b1, 32'h0000_0080);
        repeat (3) @(posedge clk);
        chk(irq, 32'h0000_0000);
        bus(OFF_IRQ4, 1'b0, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        // Every halt source concurrent, then peek halt, triggered bp
        for (int i = 1; i < 6; i++) begin
            m = (i < 4) ? 0 : 6 - i;
            s = (i < 4) ? i : i - 3;
            bus(OFF_CTRL, 1'b1, 32'h0000_0080 | m);
            halt_cmd <= 1'b1;
            src_cmd <= halt_src_e'(s);
            wait_for(debug_entered, 1'b1);
            halt_cmd <= 1'b0;
            bus(OFF_CTRL, 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0080 | m);
            bus(OFF_STAT, 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0001 | (s != 2) << 3);
            pulse_exit();
            wait_for(debug_entered, 1'b0);
            chk(instr_execute, s != 3);
            chk(flash_read, s != 2);
        end
        // Stepped and breakpoint scans finish before entry
        bus(OFF_CTRL, 1'b1, 32'h0000_0080);
        for (int k = 0; k < 2; k++) begin
            single_step <= (k == 0);
            sw_breakpoint <= (k == 1);
            @(posedge clk);
            single_step <= 1'b0;
            sw_breakpoint <= 1'b0;
            @(posedge clk);
            chk(flash_read, 32'h0000_0001);
            chk(instr_stall, k);
            chk(instr_execute, k == 0);
            wait_for(debug_entered, 1'b1);
            bus(OFF_STAT, 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0001);
            pulse_exit();
            wait_for(debug_entered, 1'b0);
        end
        // Go instruction hit by step, breakpoint or halt: burst after exit
        bus(OFF_HADR, 1'b1, 32'h0000_0003);
        bus(OFF_CTRL, 1'b1, 32'h0000_0083);
        src_cmd <= HALT_EXTERNAL;
        for (int k = 0; k < 3; k++) begin
            bus(OFF_LADR, 1'b1, 32'h0000_0000);
            halt_cmd <= (k == 2);
            @(posedge clk);
            instr_sets_go <= 1'b1;
            single_step <= (k == 0);
            sw_breakpoint <= (k == 1);
            wait_for(debug_entered, 1'b1);
            {halt_cmd, instr_sets_go, single_step, sw_breakpoint} <= 4'h0;
            chk(exec_from_debug_reg, k == 1);
            bus(OFF_STAT, 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0005 | (k == 1) << 1);
            bus(OFF_CTRL, 1'b0, 32'h0000_0000);
            chk(q, 32'h0000_0083);
            pulse_exit();
            wait_for(debug_entered, 1'b0);
            chk(instr_execute, 32'h0000_0001);
            wait_for(irq, 1'b1);
            chk(flash_addr, 32'h0000_0004);
            bus(OFF_IRQ4, 1'b1, 32'h0000_0080);
        end
        // Watchdog keeps counting through a burst
        bus(OFF_WDT, 1'b1, 32'h0000_0001);
        bus(OFF_CTRL, 1'b1, 32'h0000_00C3);
        wait_for(wdt_reset, 1'b1);
        chk(wdt_reset, 32'h0000_0001);
        // Reset in mid-burst returns the scanner to its reset state
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(flash_addr, 32'(ADDR_RESET));
        bus(OFF_CTRL, 1'b0, 32'h0000_0000);
        chk(q, 32'(CTRL_RESET));
        report_and_stop();
    end
endmodule

bind scan_halt_ctrl scan_halt_assertions #(.WDT_CYCLES(WDT_CYCLES)) u_chk (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .debug_exit, .debug_entered,
    .instr_stall, .instr_execute, .flash_read, .flash_addr, .irq,
    .wdt_reset);
`default_nettype wire
